/* logic/lamp_driver_regs.v */
// Purpose: write-only serial target and register bank for a one-channel lamp driver
// Assumes: scl and sda come from pins and are oversampled by clk_sys
// Notes: no read path; breathing sequencer and analog sink live elsewhere
// What this block does
// R1 - answer only target address 1101000
// R2 - writes only; direction bit must be zero
// R3 - master keeps serial clock at most 400kHz; bench host clocks at 145 ns or 620 ns periods
// R4 - sample data while serial clock high
// R5 - idle data line stays released high
// R6 - start: data falls, clock high; compare address
// R7 - address byte sent msb first
// R8 - pull data low on matching address acknowledge
// R9 - master stops if no acknowledge
// R10 - second byte loads register pointer, acknowledged
// R11 - data bytes written at pointer, acknowledged
// R12 - stop: data rises, clock high; back idle
// R13 - pointer advances by one per data byte
// R14 - 00h: soft sleep D0, channel enable D5
// R15 - 01h D5 enables ramping
// R16 - 01h D4 picks hold in T2 or T4
// R17 - 02h D5 picks PWM or one-shot mode
// R18 - 03h D4:D2 selects full-scale current
// R19 - 04h duty in 256 steps, PWM mode
// R20 - write to 07h loads active duty
// R21 - write to 1Ch loads active timing
// R22 - write to 2Fh restores all defaults
// R23 - duty shadowed; master writes zero to load
// R24 - timing shadowed; master writes zero to load
// R25 - 1Dh D0 switches output on, default on
// R26 - one-shot peak uses 04h D7:D1, 128 steps
// R27 - undefined addresses acknowledged, data dropped
// R28 - sleep pin low turns output off
`timescale 1ns/1ps
`default_nettype none
`include "lamp_driver_defs.vh"

module lamp_driver_regs #(
   parameter [6:0] TARGET = `TARGET_ADDR
) (
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   input wire clk_en,
   // serial pins
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output reg sda_oe,
   // hardware shutdown pin
   input wire sleep_pin_n,
   // register outputs toward the analog side
   output reg soft_sleep_bit,
   output reg chan_enable,
   output reg ramp_allow_bit,
   output reg hold_pick_bit,
   output reg mode_pick_bit,
   output reg [2:0] full_scale_sel,
   output reg [7:0] duty_active,
   output reg [6:0] peak_level,
   output reg [7:0] start_delay_active,
   output reg [7:0] rise_hold_active,
   output reg [7:0] fall_off_active,
   output reg output_switch,
   output reg output_on,
   output reg busy
);

   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_BITS = 2'd1;
   localparam [1:0] ST_ACK = 2'd2;
   localparam [1:0] ST_SKIP = 2'd3;

   localparam [1:0] PH_ADDR = 2'd0;
   localparam [1:0] PH_PTR = 2'd1;
   localparam [1:0] PH_DATA = 2'd2;

   // two-flop synchronisers; stage one is read only by stage two
   reg [1:0] sclSync;
   reg [1:0] sdaSync;
   reg [1:0] slpSync;
   reg sclPrev;
   reg sdaPrev;
   reg [1:0] state;
   reg [1:0] phase;
   reg [2:0] bitCount;
   reg [7:0] shiftReg;
   reg [7:0] pointer;
   reg ackHigh;
   reg [7:0] regShutdown;
   reg [7:0] regBreath;
   reg [7:0] regMode;
   reg [7:0] regCurrent;
   reg [7:0] duty;
   reg [7:0] startDelay;
   reg [7:0] riseHold;
   reg [7:0] fallOff;
   reg [7:0] regSwitch;
   reg [7:0] dutyLive;
   reg [7:0] startLive;
   reg [7:0] riseLive;
   reg [7:0] fallLive;

   wire scl = sclSync[1];
   wire sda = sdaSync[1];
   wire sclRise = scl & ~sclPrev;
   wire sclFall = ~scl & sclPrev;
   wire startSeen = scl & sclPrev & sdaPrev & ~sda;  // see R6
   wire stopSeen = scl & sclPrev & ~sdaPrev & sda;   // see R12
   wire [7:0] byteIn = {shiftReg[6:0], sda};

   // open-drain data: only ever drive low
   assign sda_out = 1'b0;

   function is_offset;
      input [7:0] ptr;
      input [7:0] ofs;
      begin
         is_offset = (ptr == ofs);
      end
   endfunction

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sclSync <= 2'b11;
         sdaSync <= 2'b11;
         slpSync <= 2'b11;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else if (clk_en) begin
         sclSync <= {sclSync[0], scl_in};
         sdaSync <= {sdaSync[0], sda_in};
         slpSync <= {slpSync[0], sleep_pin_n};
         sclPrev <= scl;
         sdaPrev <= sda;
      end
   end

   // serial receive engine
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         phase <= PH_ADDR;
         bitCount <= 3'd0;
         shiftReg <= 8'h00;
         pointer <= 8'h00;
         sda_oe <= 1'b0;
         ackHigh <= 1'b0;
         regShutdown <= `RST_SHUTDOWN;
         regBreath <= `RST_ZERO;
         regMode <= `RST_ZERO;
         regCurrent <= `RST_ZERO;
         duty <= `RST_ZERO;
         startDelay <= `RST_ZERO;
         riseHold <= `RST_ZERO;
         fallOff <= `RST_ZERO;
         regSwitch <= `RST_SWITCH;
         dutyLive <= `RST_ZERO;
         startLive <= `RST_ZERO;
         riseLive <= `RST_ZERO;
         fallLive <= `RST_ZERO;
      end else if (clk_en) begin
         if (startSeen) begin
            // a repeated start also lands here
            state <= ST_BITS;  // see R6
            phase <= PH_ADDR;
            bitCount <= 3'd0;
            sda_oe <= 1'b0;
            ackHigh <= 1'b0;
         end else if (stopSeen) begin
            state <= ST_IDLE;  // see R12
            sda_oe <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  sda_oe <= 1'b0;
               end
               ST_BITS: begin
                  if (sclRise) begin
                     shiftReg <= byteIn;  // see R4 R7
                     bitCount <= bitCount + 3'd1;
                     if (bitCount == 3'd7) begin
                        state <= ST_ACK;
                        ackHigh <= 1'b0;
                        case (phase)
                           PH_ADDR: begin
                              // a read request or foreign address is not answered
                              if (byteIn[7:1] == TARGET && !byteIn[0]) begin  // see R1 R2
                                 phase <= PH_PTR;
                              end else begin
                                 state <= ST_SKIP;
                              end
                           end
                           PH_PTR: begin
                              pointer <= byteIn;  // see R10
                              phase <= PH_DATA;
                           end
                           PH_DATA: begin
                              if (is_offset(pointer, `OFS_SHUTDOWN)) begin
                                 regShutdown <= byteIn;  // see R14
                              end
                              if (is_offset(pointer, `OFS_BREATH)) begin
                                 regBreath <= byteIn;  // see R15 R16
                              end
                              if (is_offset(pointer, `OFS_MODE)) begin
                                 regMode <= byteIn;  // see R17
                              end
                              if (is_offset(pointer, `OFS_CURRENT)) begin
                                 regCurrent <= byteIn;  // see R18
                              end
                              if (is_offset(pointer, `OFS_DUTY)) begin
                                 duty <= byteIn;  // see R23
                              end
                              if (is_offset(pointer, `OFS_START_DELAY)) begin
                                 startDelay <= byteIn;  // see R24
                              end
                              if (is_offset(pointer, `OFS_RISE_HOLD)) begin
                                 riseHold <= byteIn;
                              end
                              if (is_offset(pointer, `OFS_FALL_OFF)) begin
                                 fallOff <= byteIn;
                              end
                              if (is_offset(pointer, `OFS_SWITCH)) begin
                                 regSwitch <= byteIn;  // see R25
                              end
                              // any byte value loads; master is expected to send zero
                              if (is_offset(pointer, `OFS_DUTY_LOAD)) begin
                                 dutyLive <= duty;  // see R20
                              end
                              if (is_offset(pointer, `OFS_TIME_LOAD)) begin
                                 startLive <= startDelay;  // see R21
                                 riseLive <= riseHold;
                                 fallLive <= fallOff;
                              end
                              if (is_offset(pointer, `OFS_GLOBAL_RESET)) begin
                                 regShutdown <= `RST_SHUTDOWN;  // see R22
                                 regBreath <= `RST_ZERO;
                                 regMode <= `RST_ZERO;
                                 regCurrent <= `RST_ZERO;
                                 duty <= `RST_ZERO;
                                 startDelay <= `RST_ZERO;
                                 riseHold <= `RST_ZERO;
                                 fallOff <= `RST_ZERO;
                                 regSwitch <= `RST_SWITCH;
                                 dutyLive <= `RST_ZERO;
                                 startLive <= `RST_ZERO;
                                 riseLive <= `RST_ZERO;
                                 fallLive <= `RST_ZERO;
                              end
                              // other offsets fall through unchanged, see R27
                              pointer <= pointer + 8'd1;  // see R13
                           end
                           default: begin
                              state <= ST_SKIP;
                           end
                        endcase
                     end
                  end
               end
               ST_ACK: begin
                  // drive low after the eighth falling edge, release after the ninth
                  if (sclFall) begin
                     if (!ackHigh && !sda_oe) begin
                        sda_oe <= 1'b1;  // see R8 R10 R11
                     end else if (ackHigh) begin
                        sda_oe <= 1'b0;
                        state <= ST_BITS;
                        bitCount <= 3'd0;
                     end
                  end
                  if (sclRise && sda_oe) begin
                     ackHigh <= 1'b1;
                  end
               end
               ST_SKIP: begin
                  sda_oe <= 1'b0;
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // outputs registered from the bank
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         soft_sleep_bit <= 1'b1;
         chan_enable <= 1'b0;
         ramp_allow_bit <= 1'b0;
         hold_pick_bit <= 1'b0;
         mode_pick_bit <= 1'b0;
         full_scale_sel <= `CUR_42MA;
         duty_active <= 8'h00;
         peak_level <= 7'h00;
         start_delay_active <= 8'h00;
         rise_hold_active <= 8'h00;
         fall_off_active <= 8'h00;
         output_switch <= 1'b1;
         output_on <= 1'b0;
         busy <= 1'b0;
      end else if (clk_en) begin
         soft_sleep_bit <= regShutdown[`BIT_SOFT_SLEEP];  // see R14
         chan_enable <= regShutdown[`BIT_CHAN_EN];
         ramp_allow_bit <= regBreath[`BIT_RAMP_ALLOW];  // see R15
         hold_pick_bit <= regBreath[`BIT_HOLD_PICK];  // see R16
         mode_pick_bit <= regMode[`BIT_MODE_PICK];  // see R17
         // codes 1xx all fold onto one level; the top bit is zero in the other branch
         full_scale_sel <= regCurrent[`CS_HI] ? `CUR_17MA5 : regCurrent[`CS_HI:`CS_LO];  // see R18
         duty_active <= dutyLive;  // see R19
         peak_level <= dutyLive[7:1];  // see R26
         start_delay_active <= startLive;
         rise_hold_active <= riseLive;
         fall_off_active <= fallLive;
         output_switch <= regSwitch[`BIT_SWITCH];  // see R25
         // registers keep their contents while the pin holds the output off
         output_on <= slpSync[1] & ~regShutdown[`BIT_SOFT_SLEEP]
            & regShutdown[`BIT_CHAN_EN] & regSwitch[`BIT_SWITCH];  // see R28
         busy <= (state != ST_IDLE);
      end
   end

endmodule
`default_nettype wire

/* logic/lamp_driver_defs.vh */
// Purpose: constants for the serial lamp driver register block
// Assumes: byte-wide registers at their printed offsets
// Notes: field positions are bit indices within the data byte
`ifndef LAMP_DRIVER_DEFS_VH
`define LAMP_DRIVER_DEFS_VH

`define TARGET_ADDR 7'h68
`define OFS_SHUTDOWN 8'h00
`define OFS_BREATH 8'h01
`define OFS_MODE 8'h02
`define OFS_CURRENT 8'h03
`define OFS_DUTY 8'h04
`define OFS_DUTY_LOAD 8'h07
`define OFS_START_DELAY 8'h0A
`define OFS_RISE_HOLD 8'h10
`define OFS_FALL_OFF 8'h16
`define OFS_TIME_LOAD 8'h1C
`define OFS_SWITCH 8'h1D
`define OFS_GLOBAL_RESET 8'h2F
`define BIT_SOFT_SLEEP 0
`define BIT_CHAN_EN 5
`define BIT_RAMP_ALLOW 5
`define BIT_HOLD_PICK 4
`define BIT_MODE_PICK 5
`define BIT_SWITCH 0
`define CS_HI 4
`define CS_LO 2
`define RST_SHUTDOWN 8'h01
`define RST_SWITCH 8'h01
`define RST_ZERO 8'h00
`define STROBE_VALUE 8'h00
`define CUR_42MA 3'h0
`define CUR_10MA 3'h1
`define CUR_5MA 3'h2
`define CUR_30MA 3'h3
`define CUR_17MA5 3'h4

`endif

/* tb/lamp_regs_monitor.sv */
// Purpose: concurrent checks on the lamp driver register block ports
// Assumes: pins are seen raw, before the block's synchronisers
// Notes: windows allow for the two-flop synchroniser plus output register
`timescale 1ns/1ps
`default_nettype none
module lamp_regs_monitor (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // serial and shutdown pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe,
   input wire logic sleep_pin_n,
   // register outputs
   input wire logic soft_sleep_bit,
   input wire logic chan_enable,
   input wire logic output_switch,
   input wire logic output_on,
   input wire logic [7:0] duty_active,
   input wire logic [6:0] peak_level,
   input wire logic busy
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence sStart;
      scl_in && $fell(sda_in);
   endsequence
   sequence sStop;
      scl_in && $rose(sda_in);
   endsequence
   a_start_sets_busy: assert property (sStart |-> ##[1:6] busy)
      else $error("busy missing after start");
   a_stop_clears_busy: assert property (sStop |-> ##[1:6] !busy)
      else $error("busy left after stop");
   a_ack_while_low: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("ack driven while clock high");
   a_ack_holds_high: assert property ($rose(scl_in) && sda_oe |-> sda_oe[*4])
      else $error("ack dropped during clock high");
   a_ack_in_frame: assert property (sda_oe |-> busy)
      else $error("ack outside a frame");
   a_on_needs_bits: assert property (output_on |-> !soft_sleep_bit && chan_enable
      && output_switch)
      else $error("output on against register bits");
   a_pin_forces_off: assert property (!sleep_pin_n [*5] |-> !output_on)
      else $error("output on while sleep pin low");
   a_peak_is_duty: assert property (peak_level == duty_active[7:1])
      else $error("peak level differs from duty");
   a_duty_in_frame: assert property ($changed(duty_active) |-> busy)
      else $error("duty changed outside a frame");
endmodule
bind lamp_driver_regs lamp_regs_monitor u_mon (
   .clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
   .sda_oe(sda_oe), .sleep_pin_n(sleep_pin_n), .soft_sleep_bit(soft_sleep_bit),
   .chan_enable(chan_enable), .output_switch(output_switch), .output_on(output_on),
   .duty_active(duty_active), .peak_level(peak_level), .busy(busy)
);
`default_nettype wire

/* tb/serial_host_model.sv */
// Purpose: behavioural bus master that writes to the lamp driver
// Assumes: open-drain data with a pull-up outside this model
// Notes: halfNs may be raised by the bench for a slow master
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
   // wire levels
   output var logic scl,
   output var logic sdaPull,
   input wire logic sda
);
   real halfNs;
   // idle: clock high, data released to the pull-up
   initial begin
      halfNs = 62.5; // bench sets the rate
      scl = 1'b1;
      sdaPull = 1'b0;
   end
   task automatic start();
      sdaPull = 1'b1;
      #halfNs scl = 1'b0;
      #20;
   endtask
   task automatic sendByte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sdaPull = ~b[i];
         #halfNs scl = 1'b1; // data only moves while clock low
         #halfNs scl = 1'b0;
         #20;
      end
      sdaPull = 1'b0;
      #halfNs scl = 1'b1;
      #(halfNs / 2) ack = (sda === 1'b0);
      #(halfNs / 2) scl = 1'b0;
      #20;
   endtask
   task automatic stop();
      sdaPull = 1'b1;
      #halfNs scl = 1'b1;
      #halfNs sdaPull = 1'b0;
      #halfNs;
   endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench for the lamp driver register block
// Assumes: host model drives the serial pins; clk_en held high
// Notes: outputs are compared once each frame has settled after its stop
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_sys;
   logic reset_n;
   logic sleepPinN;
   int badCount = 0;
   int nChecks = 0;
   wire logic scl, sdaPull, sdaOut, sdaOe, sda;
   wire logic softSleep, chanEn, rampAllow, holdPick, modePick, outSwitch, outOn, busy;
   wire logic [2:0] fullScale;
   wire logic [6:0] peak;
   wire logic [7:0] duty, startDelay, riseHold, fallOff;
   wire logic [7:0] flags = {outOn, softSleep, chanEn, rampAllow, holdPick, modePick,
      outSwitch, busy};
   // pull-up wins unless someone pulls low
   assign sda = ~sdaPull & (sdaOe ? sdaOut : 1'b1);
   lamp_driver_regs DUT (
      .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1), .scl_in(scl), .sda_in(sda),
      .sda_out(sdaOut), .sda_oe(sdaOe), .sleep_pin_n(sleepPinN), .soft_sleep_bit(softSleep),
      .chan_enable(chanEn), .ramp_allow_bit(rampAllow), .hold_pick_bit(holdPick),
      .mode_pick_bit(modePick), .full_scale_sel(fullScale), .duty_active(duty),
      .peak_level(peak), .start_delay_active(startDelay), .rise_hold_active(riseHold),
      .fall_off_active(fallOff), .output_switch(outSwitch), .output_on(outOn), .busy(busy)
   );
   serial_host_model host (.scl(scl), .sdaPull(sdaPull), .sda(sda));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [7:0] expV, input logic [7:0] gotV);
      nChecks++;
      if (gotV !== expV) begin
         badCount++;
         $display("wrong value %s expected %h seen %h", nm, expV, gotV);
      end
   endtask
   task automatic wr(input logic [7:0] b[$], input logic addrAck);
      logic ack;
      host.start();
      foreach (b[i]) begin
         host.sendByte(b[i], ack);
         chk("ack", {7'h0, ((i == 0) ? addrAck : 1'b1)}, {7'h0, ack});
         if (ack !== 1'b1) break;
      end
      host.stop();
      repeat (10) @(posedge clk_sys);
      #1;
   endtask
   task automatic finishTest();
      if (badCount == 0 && nChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #600000;
      badCount++;
      finishTest();
   end
   initial begin
      reset_n = 1'b0;
      sleepPinN = 1'b1;
      repeat (6) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 chk("flags", 8'h42, flags);
      wr('{8'hD0, 8'h00, 8'h20}, 1'b1);
      chk("flags", 8'hA2, flags);
      sleepPinN = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1 chk("flags", 8'h22, flags);
      sleepPinN = 1'b1;
      repeat (6) @(posedge clk_sys);
      #1 chk("flags", 8'hA2, flags);
      wr('{8'hD0, 8'h01, 8'h30, 8'h20, 8'h10}, 1'b1);
      chk("flags", 8'hBE, flags);
      for (int c = 0; c < 8; c++) begin
         wr('{8'hD0, 8'h03, {3'h0, c[2:0], 2'h0}}, 1'b1);
         chk("scale", (c > 3) ? 8'h04 : 8'(c), {5'h0, fullScale});
      end
      wr('{8'hD0, 8'h04, 8'hB5}, 1'b1);
      chk("duty", 8'h00, duty);
      wr('{8'hD0, 8'h07, 8'h00}, 1'b1);
      chk("duty", 8'hB5, duty);
      chk("peak", 8'h5A, {1'b0, peak});
      wr('{8'hD0, 8'h0A, 8'hA0}, 1'b1);
      wr('{8'hD0, 8'h10, 8'h3C}, 1'b1);
      wr('{8'hD0, 8'h16, 8'hC2}, 1'b1);
      chk("delay", 8'h00, startDelay);
      wr('{8'hD0, 8'h1C, 8'h00}, 1'b1);
      chk("delay", 8'hA0, startDelay);
      chk("rise", 8'h3C, riseHold);
      chk("fall", 8'hC2, fallOff);
      wr('{8'hD0, 8'h05, 8'hFF, 8'hFF}, 1'b1);
      chk("flags", 8'hBE, flags);
      chk("duty", 8'hB5, duty);
      wr('{8'hD2, 8'h1D, 8'h00}, 1'b0);
      wr('{8'hD1, 8'h1D, 8'h00}, 1'b0);
      chk("flags", 8'hBE, flags);
      host.halfNs = 300.0;
      wr('{8'hD0, 8'h1D, 8'h00}, 1'b1);
      host.halfNs = 62.5;
      chk("flags", 8'h3C, flags);
      wr('{8'hD0, 8'h2F, 8'h00}, 1'b1);
      chk("flags", 8'h42, flags);
      chk("duty", 8'h00, duty);
      chk("scale", 8'h00, {5'h0, fullScale});
      chk("rise", 8'h00, riseHold);
      finishTest();
   end
endmodule
`default_nettype wire
